// File: include/strobe_mem_pkg.sv
// Shared constants and types of the shared-strobe memory interface
package strobe_mem_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int WAIT_W = 3;
  // Cycles the ready and data pins need to cross the synchroniser
  localparam int SYNC_LAT = 2;

  typedef logic [1:0] size_t;
  localparam size_t SIZE_8 = 2'h0;
  localparam size_t SIZE_16 = 2'h1;
  localparam size_t SIZE_32 = 2'h2;

  typedef enum {ST_IDLE, ST_ACCESS} bus_state_t;

  localparam logic [LANES-1:0] STROBES_IDLE = 4'hf;
  localparam logic [WAIT_W-1:0] COUNT_RESET = 3'h0;
  localparam logic [1:0] BEAT_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
endpackage : strobe_mem_pkg

// File: include/xlate_if.sv
// Carrier between the bus sequencer and the address translator
`timescale 1ns/1ps
interface xlate_if;
  logic [strobe_mem_pkg::ADDR_W-1:0] logical;
  logic [1:0] beat;
  strobe_mem_pkg::size_t data_size;
  strobe_mem_pkg::size_t mem_width;
  logic [strobe_mem_pkg::ADDR_W-1:0] phys;
  logic [strobe_mem_pkg::LANES-1:0] lanes;
  logic [1:0] lane_off;
  logic [1:0] last_beat;
  modport user (
    output logical, beat, data_size, mem_width,
    input phys, lanes, lane_off, last_beat
  );
  modport xlate (
    input logical, beat, data_size, mem_width,
    output phys, lanes, lane_off, last_beat
  );
endinterface : xlate_if

// File: src/strobe_xlate.sv
// Logical to physical address and byte-lane translation
`timescale 1ns/1ps
module strobe_xlate (
  xlate_if.xlate bus
);
  function automatic logic [3:0] lane_mask(strobe_mem_pkg::size_t n);
    case (n)
      strobe_mem_pkg::SIZE_8: lane_mask = 4'h1;
      strobe_mem_pkg::SIZE_16: lane_mask = 4'h3;
      default: lane_mask = 4'hf;
    endcase
  endfunction : lane_mask

  always_comb begin
    logic [1:0] k;
    logic [1:0] idx;
    k = 2'h0;
    idx = 2'h0;
    bus.phys = bus.logical;
    bus.lanes = lane_mask(bus.data_size);
    bus.lane_off = 2'h0;
    bus.last_beat = 2'h0;
    if (bus.data_size <= bus.mem_width) begin
      // [R3] narrow data shift
      k = bus.mem_width - bus.data_size;
      bus.phys = bus.logical >> k;
      case (k)
        2'h0: idx = 2'h0;
        2'h1: idx = {1'b0, bus.logical[0]};
        default: idx = bus.logical[1:0];
      endcase
      // [R4] lane from low bits
      bus.lane_off = 2'(idx << bus.data_size);
      bus.lanes = 4'(lane_mask(bus.data_size) << bus.lane_off);
    end else begin
      // [R7] wide data, several beats
      k = bus.data_size - bus.mem_width;
      bus.phys = (bus.logical << k) | strobe_mem_pkg::ADDR_W'(bus.beat);
      bus.lanes = lane_mask(bus.mem_width);
      bus.last_beat = (k == 2'h1) ? 2'h1 : 2'h3;
    end
  end
endmodule : strobe_xlate

// File: src/shared_strobe_mem_interface.sv
// Shared two-strobe external memory bus sequencer
`timescale 1ns/1ps
// Function
// [R1] Shared mode puts both spaces on primary pins
// [R2] Each space uses its own width and size
// [R3] 16-bit data in 32-bit memory shifts address
// [R4] Primary 16-bit write drives two upper lanes
// [R5] Secondary 32-bit shared access drives four lanes
// [R6] Any size pairing, no reprogramming, no penalty
// [R7] Sharing works with 16- and 8-bit memory
// [R8] Software sets sharing, width, then size
// [R9] Software splits bank with high address bit
// [R10] Low ready sample ends cycle, else wait
// [R11] Per-strobe programmed wait states
// [R12] Board ties ready low when unneeded
// [R13] Board drives ready only for mixed banks
// [R14] Finish after wait count and ready low
module shared_strobe_mem_interface #(
  parameter int WAIT_W = strobe_mem_pkg::WAIT_W
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic strobe_share_select,
  input wire strobe_mem_pkg::size_t primary_mem_width,
  input wire strobe_mem_pkg::size_t primary_data_size,
  input wire logic [WAIT_W-1:0] primary_wait,
  input wire strobe_mem_pkg::size_t secondary_mem_width,
  input wire strobe_mem_pkg::size_t secondary_data_size,
  input wire logic [WAIT_W-1:0] secondary_wait,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_space,
  input wire logic req_write,
  input wire logic [strobe_mem_pkg::ADDR_W-1:0] req_addr,
  input wire logic [strobe_mem_pkg::DATA_W-1:0] req_wdata,
  output logic done,
  output logic [strobe_mem_pkg::DATA_W-1:0] rdata,
  output logic [strobe_mem_pkg::LANES-1:0] byte_lane_strobe_n,
  output logic [strobe_mem_pkg::LANES-1:0] secondary_strobe_n,
  output logic [strobe_mem_pkg::ADDR_W-1:0] addr_out,
  output logic [strobe_mem_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [strobe_mem_pkg::DATA_W-1:0] data_in,
  input wire logic ready_n
);
  // -----------------------------------------------------------------
  // Request capture
  // -----------------------------------------------------------------
  strobe_mem_pkg::bus_state_t state;
  strobe_mem_pkg::bus_state_t next_state;
  logic lat_space;
  logic lat_write;
  logic [strobe_mem_pkg::ADDR_W-1:0] lat_addr;
  logic [strobe_mem_pkg::DATA_W-1:0] lat_wdata;
  strobe_mem_pkg::size_t lat_size;
  strobe_mem_pkg::size_t lat_width;
  logic [WAIT_W-1:0] lat_wait;
  logic [1:0] beat;
  logic [1:0] next_beat;
  logic [1:0] cur_off;
  logic [WAIT_W-1:0] cnt;
  logic [1:0] ready_sync;
  logic [strobe_mem_pkg::DATA_W-1:0] data_meta;
  logic [strobe_mem_pkg::DATA_W-1:0] data_s;
  logic [strobe_mem_pkg::DATA_W-1:0] acc;
  logic ready_s;
  logic accept;
  logic complete;
  logic last;
  strobe_mem_pkg::size_t sel_size;
  strobe_mem_pkg::size_t sel_width;
  logic [WAIT_W-1:0] sel_wait;
  xlate_if xl ();

  strobe_xlate u_xlate (
    .bus(xl.xlate)
  );

  function automatic logic [31:0] byte_mask(strobe_mem_pkg::size_t n);
    case (n)
      strobe_mem_pkg::SIZE_8: byte_mask = 32'h000000ff;
      strobe_mem_pkg::SIZE_16: byte_mask = 32'h0000ffff;
      default: byte_mask = 32'hffffffff;
    endcase
  endfunction : byte_mask

  // Bit shift of one beat's slice within a wide data word
  function automatic logic [4:0] beat_shift(logic [1:0] b,
                                           strobe_mem_pkg::size_t w);
    beat_shift = 5'({b, 3'h0} << w);
  endfunction : beat_shift

  assign req_ready = (state == strobe_mem_pkg::ST_IDLE);
  assign accept = req_ready && req_valid;
  assign ready_s = ready_sync[1];
  assign last = (beat == xl.last_beat);

  // [R2] per-space configuration
  always_comb begin
    sel_size = req_space ? secondary_data_size : primary_data_size;
    sel_width = req_space ? secondary_mem_width : primary_mem_width;
    sel_wait = req_space ? secondary_wait : primary_wait;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      lat_space <= 1'b0;
      lat_write <= 1'b0;
      lat_addr <= strobe_mem_pkg::ADDR_RESET;
      lat_wdata <= strobe_mem_pkg::DATA_RESET;
      lat_size <= strobe_mem_pkg::SIZE_8;
      lat_width <= strobe_mem_pkg::SIZE_8;
      lat_wait <= strobe_mem_pkg::COUNT_RESET;
    end else if (accept) begin
      lat_space <= req_space;
      lat_write <= req_write;
      lat_addr <= req_addr;
      lat_wdata <= req_wdata;
      lat_size <= sel_size;
      lat_width <= sel_width;
      lat_wait <= sel_wait;
    end
  end

  // -----------------------------------------------------------------
  // Ready and data pin synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ready_sync <= 2'h3;
      data_meta <= strobe_mem_pkg::DATA_RESET;
      data_s <= strobe_mem_pkg::DATA_RESET;
    end else begin
      ready_sync <= {ready_sync[0], ready_n};
      data_meta <= data_in;
      data_s <= data_meta;
    end
  end

  // -----------------------------------------------------------------
  // Cycle sequencing and wait states
  // -----------------------------------------------------------------
  // Beats last at least the synchroniser delay, so the sampled data
  // and ready belong to the beat now on the pins.
  // [R10] [R11] [R14] wait then ready
  assign complete = (state == strobe_mem_pkg::ST_ACCESS)
                 && (cnt >= lat_wait)
                 && (cnt >= WAIT_W'(strobe_mem_pkg::SYNC_LAT))
                 && !ready_s;

  always_comb begin
    next_state = state;
    next_beat = beat;
    if (accept) begin
      next_state = strobe_mem_pkg::ST_ACCESS;
      next_beat = strobe_mem_pkg::BEAT_RESET;
    end else if (complete) begin
      if (last) begin
        next_state = strobe_mem_pkg::ST_IDLE;
      end else begin
        // [R6] extra beats only for wide data
        next_beat = beat + 2'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= strobe_mem_pkg::ST_IDLE;
      beat <= strobe_mem_pkg::BEAT_RESET;
    end else begin
      state <= next_state;
      beat <= next_beat;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || accept || complete) begin
      cnt <= strobe_mem_pkg::COUNT_RESET;
    end else if (state == strobe_mem_pkg::ST_ACCESS && cnt != '1) begin
      cnt <= cnt + 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Translation for the beat on the pins next cycle
  // -----------------------------------------------------------------
  always_comb begin
    xl.logical = accept ? req_addr : lat_addr;
    xl.data_size = accept ? sel_size : lat_size;
    xl.mem_width = accept ? sel_width : lat_width;
    xl.beat = next_beat;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      byte_lane_strobe_n <= strobe_mem_pkg::STROBES_IDLE;
      secondary_strobe_n <= strobe_mem_pkg::STROBES_IDLE;
      addr_out <= strobe_mem_pkg::ADDR_RESET;
      data_out <= strobe_mem_pkg::DATA_RESET;
      data_oe_n <= 1'b1;
      cur_off <= 2'h0;
    end else begin
      byte_lane_strobe_n <= strobe_mem_pkg::STROBES_IDLE;
      secondary_strobe_n <= strobe_mem_pkg::STROBES_IDLE;
      data_oe_n <= 1'b1;
      if (next_state == strobe_mem_pkg::ST_ACCESS) begin
        // [R1] shared pin routing
        if ((accept ? req_space : lat_space) && !strobe_share_select) begin
          secondary_strobe_n <= ~xl.lanes;
        end else begin
          byte_lane_strobe_n <= ~xl.lanes;
        end
        addr_out <= xl.phys;
        cur_off <= xl.lane_off;
        data_oe_n <= !(accept ? req_write : lat_write);
        // [R4] [R5] place data on lanes
        if (xl.data_size <= xl.mem_width) begin
          data_out <= (accept ? req_wdata : lat_wdata) << {xl.lane_off, 3'h0};
        end else begin
          // First beat is launched on the accept edge, before the latch
          data_out <= (accept ? req_wdata : lat_wdata)
              >> beat_shift(next_beat, xl.mem_width);
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Read data assembly
  // -----------------------------------------------------------------
  logic [strobe_mem_pkg::DATA_W-1:0] piece;
  always_comb begin
    if (lat_size <= lat_width) begin
      piece = (data_s >> {cur_off, 3'h0}) & byte_mask(lat_size);
    end else begin
      piece = (data_s & byte_mask(lat_width)) << beat_shift(beat, lat_width);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      acc <= strobe_mem_pkg::DATA_RESET;
      rdata <= strobe_mem_pkg::DATA_RESET;
      done <= 1'b0;
    end else begin
      done <= complete && last;
      if (accept) begin
        acc <= strobe_mem_pkg::DATA_RESET;
      end else if (complete) begin
        acc <= acc | piece;
      end
      if (complete && last && !lat_write) begin
        rdata <= acc | piece;
      end
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  wire busy = (state == strobe_mem_pkg::ST_ACCESS);
  wire narrow_start = accept && sel_size <= sel_width && sel_wait == '0;

  sequence start_s;
    narrow_start;
  endsequence
  sequence ready_low_s;
    !ready_s [*3];
  endsequence

  idle_strobes_a: assert property (!busy |-> byte_lane_strobe_n == 4'hf
      && secondary_strobe_n == 4'hf)
    else $error("strobe active outside a bus cycle");
  shared_pins_a: assert property ( // [R1]
    busy && lat_space && strobe_share_select |->
      secondary_strobe_n == 4'hf && byte_lane_strobe_n != 4'hf)
    else $error("shared access not on primary pins");
  addr_shift_a: assert property ( // [R3]
    busy && lat_size == strobe_mem_pkg::SIZE_16
      && lat_width == strobe_mem_pkg::SIZE_32 |-> addr_out == lat_addr >> 1)
    else $error("halfword address not shifted by one");
  half_upper_a: assert property ( // [R4]
    busy && !lat_space && lat_write && lat_addr[0]
      && lat_size == strobe_mem_pkg::SIZE_16
      && lat_width == strobe_mem_pkg::SIZE_32 |->
      byte_lane_strobe_n == 4'h3 && !data_oe_n)
    else $error("upper halfword write lanes wrong");
  full_word_a: assert property ( // [R5]
    busy && lat_space && strobe_share_select
      && lat_size == strobe_mem_pkg::SIZE_32
      && lat_width == strobe_mem_pkg::SIZE_32 |-> byte_lane_strobe_n == 4'h0)
    else $error("shared word access lanes wrong");
  one_beat_a: assert property ( // [R6]
    start_s ##1 ready_low_s |=> done)
    else $error("narrow access took extra cycles");
  ready_hold_a: assert property ( // [R10]
    busy && ready_s |=> !done)
    else $error("cycle ended without ready");
  wait_count_a: assert property ( // [R11]
    $rose(busy) && lat_wait == 3'h3 |-> !done [*4])
    else $error("programmed wait states cut short");
  both_met_a: assert property ( // [R14]
    done |-> $past(cnt) >= lat_wait && !$past(ready_s))
    else $error("cycle ended before wait and ready");
endmodule : shared_strobe_mem_interface

// File: testbench/sram_ready_model.sv
// Far-side SRAM bank with board ready logic
`timescale 1ns/1ps
module sram_ready_model (
  input wire logic clock,
  input wire logic [3:0] byte_lane_strobe_n,
  input wire logic [3:0] secondary_strobe_n,
  input wire logic [23:0] addr_out,
  input wire logic [31:0] data_out,
  input wire logic data_oe_n,
  input wire logic [3:0] ready_delay,
  output logic [31:0] data_in,
  output logic ready_n
);
  logic [31:0] mem [0:262143];
  logic [31:0] last = 32'h00000000;
  logic [3:0] cnt = 4'h0;
  logic [3:0] lanes;
  logic rd;
  assign lanes = ~byte_lane_strobe_n | ~secondary_strobe_n;
  assign rd = lanes != 4'h0 && data_oe_n;
  // Released bus toggles so stale data never matches
  assign data_in = rd ? mem[addr_out[17:0]] : ~last;
  // ready low after the commanded delay
  // No delay asked stands for a board that ties ready low for good
  assign ready_n = !((lanes != 4'h0 && cnt >= ready_delay)
                     || ready_delay == 4'h0);
  always @(posedge clock) begin
    last <= data_in;
    cnt <= (lanes == 4'h0) ? 4'h0 : cnt + 4'(cnt != 4'hf);
    for (int i = 0; i < 4; i++) begin
      if (lanes[i] && !data_oe_n) begin
        mem[addr_out[17:0]][8*i +: 8] <= data_out[8*i +: 8];
      end
    end
  end
endmodule : sram_ready_model

// File: testbench/shared_strobe_mem_interface_test.sv
// Self-checking bench of the shared-strobe memory interface
`timescale 1ns/1ps
module shared_strobe_mem_interface_test;
  typedef struct {logic [3:0] pn; logic [3:0] sn; logic [23:0] pa;} pin_t;
  typedef struct {int lat; logic rd; logic [31:0] val;} res_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic share = 1'b1;
  strobe_mem_pkg::size_t pw = 2'h2, pd = 2'h2, sw = 2'h2, sd = 2'h2;
  logic [2:0] pwait = 3'h0, swait = 3'h0;
  logic [3:0] rdly = 4'h0;
  logic req_valid = 1'b0, req_space = 1'b0, req_write = 1'b0;
  logic [23:0] req_addr = 24'h000000, addr_out;
  logic [31:0] req_wdata = 32'h00000000, rdata, data_out, data_in;
  logic req_ready, done, data_oe_n, ready_n;
  logic [3:0] byte_lane_strobe_n, secondary_strobe_n;
  logic [3:0] prev_n = 4'hf;
  pin_t pin_q[$];
  res_t res_q[$];
  res_t r;
  int error_cnt = 0, checked = 0, cyc = 0, t_take = 0;

  always #25 clock = ~clock;

  shared_strobe_mem_interface u_dut (.clock(clock), .rstn(rstn),
    .strobe_share_select(share), .primary_mem_width(pw),
    .primary_data_size(pd), .primary_wait(pwait),
    .secondary_mem_width(sw), .secondary_data_size(sd),
    .secondary_wait(swait), .req_valid(req_valid), .req_ready(req_ready),
    .req_space(req_space), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .done(done), .rdata(rdata),
    .byte_lane_strobe_n(byte_lane_strobe_n),
    .secondary_strobe_n(secondary_strobe_n), .addr_out(addr_out),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in),
    .ready_n(ready_n));

  sram_ready_model u_mem (.clock(clock),
    .byte_lane_strobe_n(byte_lane_strobe_n),
    .secondary_strobe_n(secondary_strobe_n), .addr_out(addr_out),
    .data_out(data_out), .data_oe_n(data_oe_n), .ready_delay(rdly),
    .data_in(data_in), .ready_n(ready_n));

  // ------------------------------------------------------------
  // Checks and reporting
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic fail(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail

  task automatic cmp_pins(input pin_t e);
    checked++;
    if (byte_lane_strobe_n !== e.pn || secondary_strobe_n !== e.sn ||
        addr_out !== e.pa) fail("strobe or address pins");
  endtask : cmp_pins

  task automatic cmp_lat(input int e);
    checked++;
    if (cyc - t_take != e) fail("access length");
  endtask : cmp_lat

  task automatic cmp_data(input logic [31:0] e);
    checked++;
    if (rdata !== e) fail("read data");
  endtask : cmp_data

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail("run too long");
      report_and_stop();
    end
  end

  always @(negedge clock) begin
    if (rstn && prev_n == 4'hf &&
        (byte_lane_strobe_n & secondary_strobe_n) != 4'hf) begin
      cmp_pins(pin_q.pop_front());
    end
    prev_n <= byte_lane_strobe_n & secondary_strobe_n;
    if (rstn && done === 1'b1) begin
      r = res_q.pop_front();
      if (r.lat != 0) cmp_lat(r.lat);
      if (r.rd) cmp_data(r.val);
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  task automatic access(input logic sp, input logic wr,
                        input logic [23:0] a, input logic [31:0] wd);
    int d, w, k, wt, n;
    logic [3:0] ln;
    pin_t p;
    res_t e;
    @(posedge clock);
    d = sp ? sd : pd;
    w = sp ? sw : pw;
    wt = sp ? swait : pwait;
    if (d <= w) begin
      k = w - d;
      p.pa = a >> k;
      ln = ((4'h1 << (1 << d)) - 4'h1) << ((a & ((1 << k) - 1)) << d);
    end else begin
      p.pa = a << (d - w);
      ln = (4'h1 << (1 << w)) - 4'h1;
    end
    p.pn = (sp && !share) ? 4'hf : ~ln;
    p.sn = (sp && !share) ? ~ln : 4'hf;
    e.lat = (d <= w) ? ((wt > rdly + 2) ? wt : rdly + 2) + 2 : 0;
    e.rd = !wr;
    e.val = 32'(wd & ((64'h1 << (8 << d)) - 64'h1));
    pin_q.push_back(p);
    res_q.push_back(e);
    req_valid <= 1'b1;
    req_space <= sp;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= wd;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    t_take = cyc;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n >= 300) fail("no completion");
  endtask : access

  initial begin
    logic [23:0] a;
    logic [31:0] wd;
    void'($urandom(32'hff6c21f2));
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    for (int s = 1; s >= 0; s--) begin
      for (int c = 0; c < 9; c++) begin
        @(posedge clock);
        share <= s[0];
        @(posedge clock);
        pw <= 2'(c / 3);
        sw <= 2'(c / 3);
        @(posedge clock);
        pd <= 2'(c % 3);
        sd <= 2'((c + 1) % 3);
        // Fixed waits at c 0 and the fixed primary wait at c 3 reach the timing checks
        pwait <= (c == 0) ? 3'h0 : (c == 3) ? 3'h3 : 3'($urandom_range(7));
        swait <= (c == 0) ? 3'h0 : 3'($urandom_range(7));
        rdly <= (c == 0) ? 4'h0 : 4'($urandom_range(4));
        for (int sp = 0; sp < 2; sp++) begin
          // halves told apart by a high bit
          a = {sp ? 8'h92 : 8'h88, 16'($urandom)};
          // Odd primary address reaches the upper halfword lanes
          if (sp == 0 && s == 1) a[0] = 1'b1;
          wd = $urandom;
          access(1'(sp), 1'b1, a, wd);
          access(1'(sp), 1'b0, a, wd);
        end
      end
    end
    repeat (4) @(posedge clock);
    report_and_stop();
  end
endmodule : shared_strobe_mem_interface_test
